// File: hdl/ocdx_pkg.sv
// ocdx_pkg: opcode patterns, operation codes and decode result type for the opcode decoder
package ocdx_pkg;

   // single-byte and first-byte opcode patterns
   localparam logic [7:0] OP_SEG_LOAD      = 8'h8e;  // segment register from reg/mem
   localparam logic [7:0] OP_SEG_STORE     = 8'h8c;  // segment register to reg/mem
   localparam logic [7:0] OP_XLATE         = 8'hd7;  // table translate
   localparam logic [7:0] OP_EA_LOAD       = 8'h8d;  // effective address load
   localparam logic [7:0] OP_PTR_DS        = 8'hc5;  // pointer load, data segment
   localparam logic [7:0] OP_PTR_ES        = 8'hc4;  // pointer load, extra segment
   localparam logic [7:0] OP_FLAGS_TO_AH   = 8'h9f;  // flags into high accumulator byte
   localparam logic [7:0] OP_AH_TO_FLAGS   = 8'h9e;  // high accumulator byte into flags
   localparam logic [7:0] OP_ASC_ADD_ADJ   = 8'h37;  // unpacked add correction
   localparam logic [7:0] OP_DEC_ADD_ADJ   = 8'h27;  // packed add correction
   localparam logic [7:0] OP_ASC_SUB_ADJ   = 8'h3f;  // unpacked subtract correction
   localparam logic [7:0] OP_DEC_SUB_ADJ   = 8'h2f;  // packed subtract correction
   localparam logic [7:0] OP_ASC_MUL_ADJ   = 8'hd4;  // unpacked multiply correction
   localparam logic [7:0] OP_ASC_DIV_ADJ   = 8'hd5;  // unpacked divide correction
   localparam logic [7:0] OP_ADJ_SECOND    = 8'h0a;  // mandatory second byte of the two above
   localparam logic [7:0] OP_BYTE_TO_WORD  = 8'h98;  // sign extend byte to word
   localparam logic [7:0] OP_WORD_TO_DWORD = 8'h99;  // sign extend word to doubleword

   // masked first-byte patterns: upper six or seven bits
   localparam logic [5:0] PF_ADC_RM    = 6'h04;  // 000100dw
   localparam logic [6:0] PF_ADC_ACC   = 7'h0a;  // 0001010w
   localparam logic [5:0] PF_SUB_RM    = 6'h0a;  // 001010dw
   localparam logic [5:0] PF_SBB_RM    = 6'h06;  // 000110dw
   localparam logic [6:0] PF_UNARY_GRP = 7'h7b;  // 1111011w
   localparam logic [5:0] PF_SHIFT_GRP = 6'h34;  // 110100vw
   localparam logic [5:0] PF_IMM_GRP   = 6'h20;  // 100000sw

   // middle subcodes of the addressing byte
   localparam logic [2:0] SC_000 = 3'h0;
   localparam logic [2:0] SC_001 = 3'h1;
   localparam logic [2:0] SC_010 = 3'h2;
   localparam logic [2:0] SC_011 = 3'h3;
   localparam logic [2:0] SC_100 = 3'h4;
   localparam logic [2:0] SC_101 = 3'h5;
   localparam logic [2:0] SC_110 = 3'h6;
   localparam logic [2:0] SC_111 = 3'h7;

   // bit positions within the first byte
   localparam int BIT_W   = 0;  // width bit
   localparam int BIT_DSV = 1;  // direction / sign-extend / count-source bit

   // decoded operation
   typedef enum logic [5:0] {
      OCDX_NONE, OCDX_SEG_LOAD, OCDX_SEG_STORE, OCDX_XLATE, OCDX_EA_LOAD,
      OCDX_PTR_DS, OCDX_PTR_ES, OCDX_FLAGS_TO_AH, OCDX_AH_TO_FLAGS,
      OCDX_ADC_RM, OCDX_ADC_ACC, OCDX_SUB_RM, OCDX_SBB_RM,
      OCDX_ASC_ADD_ADJ, OCDX_DEC_ADD_ADJ, OCDX_ASC_SUB_ADJ, OCDX_DEC_SUB_ADJ,
      OCDX_MUL, OCDX_SIGNED_MULTIPLY, OCDX_DIV, OCDX_SIGNED_DIVIDE, OCDX_NEG, OCDX_NOT,
      OCDX_ASC_MUL_ADJ, OCDX_ASC_DIV_ADJ, OCDX_BYTE_TO_WORD, OCDX_WORD_TO_DWORD,
      OCDX_SHL, OCDX_SHR, OCDX_SAR, OCDX_ROL, OCDX_ROR, OCDX_RCL,
      OCDX_IMM_ARITH, OCDX_ILLEGAL
   } ocdx_op_t;

   // decode result handed to the execution side
   typedef struct packed {
      ocdx_op_t   op;          // operation
      logic       word;        // 1 word operand, 0 byte operand
      logic       reg_dest;    // register field is the destination
      logic       sign_ext;    // immediate byte is sign-extended
      logic       count_reg;   // shift count from count register, else one
      logic [1:0] mode;        // addressing form field
      logic [2:0] reg_field;   // register / subcode field
      logic [2:0] rm_field;    // register/memory field
      logic [1:0] imm_bytes;   // immediate data bytes that follow
   } ocdx_dec_t;

endpackage

// File: hdl/ocdx_first_byte.sv
// ocdx_first_byte: classifies the first opcode byte
`timescale 1ns/1ps
module ocdx_first_byte (
   // opcode
   input  wire logic [7:0]       opcode,
   // classification
   output ocdx_pkg::ocdx_op_t    op_first,
   output logic                  needs_modrm,
   output logic                  needs_second
);
   import ocdx_pkg::*;

   // pure first-byte classification
   always_comb begin
      op_first     = OCDX_ILLEGAL;
      needs_modrm  = 1'b0;
      needs_second = 1'b0;
      // exact single-byte codes first
      case (opcode)
         OP_SEG_LOAD      : begin op_first = OCDX_SEG_LOAD;      needs_modrm = 1'b1; end
         OP_SEG_STORE     : begin op_first = OCDX_SEG_STORE;     needs_modrm = 1'b1; end
         OP_XLATE         : op_first = OCDX_XLATE;
         OP_EA_LOAD       : begin op_first = OCDX_EA_LOAD;       needs_modrm = 1'b1; end
         OP_PTR_DS        : begin op_first = OCDX_PTR_DS;        needs_modrm = 1'b1; end
         OP_PTR_ES        : begin op_first = OCDX_PTR_ES;        needs_modrm = 1'b1; end
         OP_FLAGS_TO_AH   : op_first = OCDX_FLAGS_TO_AH;
         OP_AH_TO_FLAGS   : op_first = OCDX_AH_TO_FLAGS;
         OP_ASC_ADD_ADJ   : op_first = OCDX_ASC_ADD_ADJ;
         OP_DEC_ADD_ADJ   : op_first = OCDX_DEC_ADD_ADJ;
         OP_ASC_SUB_ADJ   : op_first = OCDX_ASC_SUB_ADJ;
         OP_DEC_SUB_ADJ   : op_first = OCDX_DEC_SUB_ADJ;
         OP_ASC_MUL_ADJ   : begin op_first = OCDX_ASC_MUL_ADJ;   needs_second = 1'b1; end
         OP_ASC_DIV_ADJ   : begin op_first = OCDX_ASC_DIV_ADJ;   needs_second = 1'b1; end
         OP_BYTE_TO_WORD  : op_first = OCDX_BYTE_TO_WORD;
         OP_WORD_TO_DWORD : op_first = OCDX_WORD_TO_DWORD;
         default: begin
            // masked groups
            if (opcode[7:2] == PF_ADC_RM) begin
               op_first = OCDX_ADC_RM;
               needs_modrm = 1'b1;
            end else if (opcode[7:1] == PF_ADC_ACC) begin
               op_first = OCDX_ADC_ACC;
            end else if (opcode[7:2] == PF_SUB_RM) begin
               op_first = OCDX_SUB_RM;
               needs_modrm = 1'b1;
            end else if (opcode[7:2] == PF_SBB_RM) begin
               op_first = OCDX_SBB_RM;
               needs_modrm = 1'b1;
            end else if (opcode[7:1] == PF_UNARY_GRP) begin
               op_first = OCDX_NONE;  // subcode picks the operation
               needs_modrm = 1'b1;
            end else if (opcode[7:2] == PF_SHIFT_GRP) begin
               op_first = OCDX_NONE;
               needs_modrm = 1'b1;
            end else if (opcode[7:2] == PF_IMM_GRP) begin
               op_first = OCDX_IMM_ARITH;
               needs_modrm = 1'b1;
            end
         end
      endcase
   end

endmodule // ocdx_first_byte

// File: hdl/ocdx_subcode.sv
// ocdx_subcode: resolves the operation of shared opcodes from the middle subcode
`timescale 1ns/1ps
module ocdx_subcode (
   // inputs
   input  wire logic [7:0]       opcode,
   input  wire logic [2:0]       subcode,
   input  ocdx_pkg::ocdx_op_t    op_first,
   // result
   output ocdx_pkg::ocdx_op_t    op_final
);
   import ocdx_pkg::*;

   // subcode tables of the unary and shift groups
   always_comb begin
      op_final = op_first;
      if (opcode[7:1] == PF_UNARY_GRP) begin
         case (subcode)
            SC_100 : op_final = OCDX_MUL;
            SC_110 : op_final = OCDX_DIV;
            SC_011 : op_final = OCDX_NEG;
            SC_010 : op_final = OCDX_NOT;
            SC_101 : op_final = OCDX_SIGNED_MULTIPLY;
            SC_111 : op_final = OCDX_SIGNED_DIVIDE;
            default: op_final = OCDX_ILLEGAL;  // other subcodes outside this decoder
         endcase
      end else if (opcode[7:2] == PF_SHIFT_GRP) begin
         case (subcode)
            SC_100 : op_final = OCDX_SHL;
            SC_101 : op_final = OCDX_SHR;
            SC_111 : op_final = OCDX_SAR;
            SC_000 : op_final = OCDX_ROL;
            SC_001 : op_final = OCDX_ROR;
            SC_010 : op_final = OCDX_RCL;
            default: op_final = OCDX_ILLEGAL;
         endcase
      end else if ((op_first == OCDX_SEG_LOAD || op_first == OCDX_SEG_STORE) && subcode[2]) begin
         op_final = OCDX_ILLEGAL;  // segment field must have a clear top bit
      end
   end

endmodule // ocdx_subcode

// File: hdl/ocdx_decoder.sv
// ocdx_decoder: byte-serial opcode decoder for transfer, arithmetic and logic groups
`timescale 1ns/1ps
// Summary of operation
// - 8e plus modrm: load segment register
// - 8c plus modrm: store segment register
// - d7 alone: table translate
// - 8d plus modrm: effective address load
// - c5 plus modrm: pointer load data segment
// - c4 plus modrm: pointer load extra segment
// - 9f alone: flags to high accumulator
// - 9e alone: high accumulator to flags
// - add-with-carry register and accumulator forms
// - subtract and subtract-with-borrow register forms
// - 37 alone: unpacked add correction
// - 27 alone: packed add correction
// - 3f alone: unpacked subtract correction
// - 2f alone: packed subtract correction
// - unary group: multiply, divide, negate, invert
// - unary subcode 101: signed multiply
// - unary subcode 111: signed divide
// - d4 0a: multiply correction, both consumed
// - d5 0a: divide correction, both consumed
// - 98, 99: sign extensions
// - shift group: left, logical right, count source
// - shift group: arithmetic right, rotate left and right, rotate left through carry
module ocdx_decoder (
   // clock and reset
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   // byte stream from the prefetch queue
   input  wire logic [7:0]          byte_data,
   input  wire logic                byte_valid,
   output logic                     byte_ready,
   // decode result
   output ocdx_pkg::ocdx_dec_t      dec_out,
   output logic                     dec_valid,
   output logic                     dec_bad_second,
   // execution side accepts the result
   input  wire logic                dec_ack
);
   import ocdx_pkg::*;

   // decoder states
   typedef enum logic [1:0] {
      ST_OPCODE, ST_MODRM, ST_SECOND, ST_HOLD
   } ocdx_state_t;

   ocdx_state_t state_q;      // current state
   ocdx_state_t state_d;      // next state
   logic [7:0]  opcode_q;     // latched first byte
   ocdx_op_t    op_first_c;   // first byte classification of incoming byte
   ocdx_op_t    op_first_q;   // held classification
   logic        need_modrm_c; // incoming opcode needs an addressing byte
   logic        need_sec_c;   // incoming opcode needs a fixed second byte
   ocdx_op_t    op_final_c;   // operation after subcode resolution
   logic        take_c;       // a byte is accepted this cycle

   // immediate byte count for the immediate forms
   function automatic logic [1:0] imm_count(input ocdx_op_t op, input logic s, input logic w);
      logic [1:0] n;
      n = 2'h0;
      if (op == OCDX_IMM_ARITH) begin
         n = ({s, w} == 2'h1) ? 2'h2 : 2'h1;
      end else if (op == OCDX_ADC_ACC) begin
         n = w ? 2'h2 : 2'h1;
      end
      return n;
   endfunction

   // classifier of the byte on the input
   ocdx_first_byte u_first (
      .opcode       (byte_data),
      .op_first     (op_first_c),
      .needs_modrm  (need_modrm_c),
      .needs_second (need_sec_c)
   );

   // subcode resolver uses the latched opcode and the incoming addressing byte
   ocdx_subcode u_sub (
      .opcode   (opcode_q),
      .subcode  (byte_data[5:3]),
      .op_first (op_first_q),
      .op_final (op_final_c)
   );

   // accept bytes only while not holding a result
   assign take_c = byte_valid && byte_ready;

   // next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_OPCODE: begin
            if (take_c) begin
               if (need_modrm_c) begin
                  state_d = ST_MODRM;
               end else if (need_sec_c) begin
                  state_d = ST_SECOND;
               end else begin
                  state_d = ST_HOLD;
               end
            end
         end
         ST_MODRM : if (take_c) state_d = ST_HOLD;
         ST_SECOND: if (take_c) state_d = ST_HOLD;
         ST_HOLD  : if (dec_ack) state_d = ST_OPCODE;
         default  : state_d = ST_OPCODE;
      endcase
   end

   // state register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_OPCODE;
      end else begin
         state_q <= state_d;
      end
   end

   // ready flag: high in fetch states, low while a result waits
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         byte_ready <= 1'b0;
      end else begin
         byte_ready <= (state_d != ST_HOLD);
      end
   end

   // latched opcode and its first classification
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         opcode_q   <= 8'h00;
         op_first_q <= OCDX_NONE;
      end else if (state_q == ST_OPCODE && take_c) begin
         opcode_q   <= byte_data;
         op_first_q <= op_first_c;
      end
   end

   // result fields
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dec_out        <= '0;
         dec_valid      <= 1'b0;
         dec_bad_second <= 1'b0;
      end else begin
         if (state_q == ST_HOLD && dec_ack) begin
            dec_valid <= 1'b0;
         end
         if (take_c) begin
            case (state_q)
               ST_OPCODE: begin
                  dec_out           <= '0;
                  dec_bad_second    <= 1'b0;
                  dec_out.op        <= op_first_c;
                  dec_out.word      <= byte_data[BIT_W];
                  dec_out.reg_dest  <= byte_data[BIT_DSV];
                  dec_out.sign_ext  <= (op_first_c == OCDX_IMM_ARITH) && byte_data[BIT_DSV];
                  dec_out.count_reg <= (byte_data[7:2] == PF_SHIFT_GRP) && byte_data[BIT_DSV];
                  dec_out.imm_bytes <= imm_count(op_first_c, byte_data[BIT_DSV], byte_data[BIT_W]);
                  // single-byte operations are complete now
                  dec_valid         <= !need_modrm_c && !need_sec_c;
               end
               ST_MODRM: begin
                  dec_out.op        <= op_final_c;
                  dec_out.mode      <= byte_data[7:6];
                  dec_out.reg_field <= byte_data[5:3];
                  dec_out.rm_field  <= byte_data[2:0];
                  dec_valid         <= 1'b1;
               end
               ST_SECOND: begin
                  // second byte is consumed either way; a wrong one marks the result illegal
                  if (byte_data != OP_ADJ_SECOND) begin
                     dec_out.op     <= OCDX_ILLEGAL;
                     dec_bad_second <= 1'b1;
                  end
                  dec_valid <= 1'b1;
               end
               default: ;
            endcase
         end
      end
   end

endmodule // ocdx_decoder

// File: dv/ocdx_asserts.sv
// ocdx_asserts: concurrent checks on the opcode decoder ports
`timescale 1ns/1ps
module ocdx_asserts (
   // clock and reset
   input wire logic                clk_sys,
   input wire logic                rst_n,
   // byte stream
   input wire logic [7:0]          byte_data,
   input wire logic                byte_valid,
   input wire logic                byte_ready,
   // decode result
   input wire ocdx_pkg::ocdx_dec_t dec_out,
   input wire logic                dec_valid,
   input wire logic                dec_bad_second,
   input wire logic                dec_ack
);
   import ocdx_pkg::*;
   logic first_q;  // next byte taken is an opcode
   logic take;     // byte handed over at this edge
   assign take = byte_valid && byte_ready;

   // opcodes that pull in a second byte
   function automatic logic two_byte(input logic [7:0] b);
      return b inside {OP_SEG_LOAD, OP_SEG_STORE, OP_EA_LOAD, OP_PTR_DS, OP_PTR_ES, OP_ASC_MUL_ADJ, OP_ASC_DIV_ADJ}
         || b[7:2] inside {PF_ADC_RM, PF_SUB_RM, PF_SBB_RM, PF_SHIFT_GRP, PF_IMM_GRP} || b[7:1] == PF_UNARY_GRP;
   endfunction

   // tells an opcode byte from the byte after it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         first_q <= 1'b1;
      end else if (take) begin
         first_q <= first_q ? !two_byte(byte_data) : 1'b1;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // opcode taken that meets a condition
   sequence first_take(c);
      first_q && take && c;
   endsequence
   // following byte taken before any result shows
   sequence second_take;
      !dec_valid throughout (##[0:29] take);
   endsequence

   ready_busy_a: assert property (dec_valid |-> !byte_ready)
      else $error("byte accepted while a result stands");
   hold_result_a: assert property (dec_valid && !dec_ack |=> dec_valid && $stable(dec_out))
      else $error("result changed before acknowledge");
   ack_release_a: assert property (dec_valid && dec_ack |=> !dec_valid ##[0:1] byte_ready)
      else $error("result not released after acknowledge");
   xlate_op_a: assert property (first_take(byte_data == OP_XLATE) |=> dec_valid && dec_out.op == OCDX_XLATE)
      else $error("table translate not decoded");
   flags_op_a: assert property (first_take(byte_data == OP_FLAGS_TO_AH) |=> dec_out.op == OCDX_FLAGS_TO_AH)
      else $error("flags copy not decoded");
   ea_load_a: assert property (first_take(byte_data == OP_EA_LOAD) ##1 second_take |=>
      dec_valid && dec_out.op == OCDX_EA_LOAD && dec_out.reg_field == $past(byte_data[5:3]))
      else $error("address load decoded wrong");
   signed_multiply_op_a: assert property (first_take(byte_data[7:1] == PF_UNARY_GRP) ##1 second_take
      ##0 byte_data[5:3] == SC_101 |=> dec_valid && dec_out.op == OCDX_SIGNED_MULTIPLY)
      else $error("signed multiply not decoded");
   mul_adjust_a: assert property (first_take(byte_data == OP_ASC_MUL_ADJ) ##1 second_take
      ##0 byte_data == OP_ADJ_SECOND |=> dec_valid && dec_out.op == OCDX_ASC_MUL_ADJ && !dec_bad_second)
      else $error("multiply adjust decoded wrong");
   bad_second_a: assert property (first_take(byte_data[7:1] == 7'h6a) ##1 second_take
      ##0 byte_data != OP_ADJ_SECOND |=> dec_valid && dec_bad_second)
      else $error("wrong adjust byte not flagged");
   imm_form_a: assert property (first_take(byte_data[7:2] == PF_IMM_GRP) |=>
      dec_out.sign_ext == $past(byte_data[1]) &&
      dec_out.imm_bytes == (($past(byte_data[1:0]) == 2'h1) ? 2'h2 : 2'h1))
      else $error("immediate form decoded wrong");
endmodule // ocdx_asserts

// File: dv/ocdx_pfq_model.sv
// ocdx_pfq_model: prefetch queue model feeding opcode bytes with random stalls
`timescale 1ns/1ps
module ocdx_pfq_model (
   // clock and reset
   input  wire logic  clk_sys,
   input  wire logic  rst_n,
   // byte stream
   input  wire logic  byte_ready,
   output logic [7:0] byte_data,
   output logic       byte_valid
);
   logic [7:0] fifo_q [$];  // bytes waiting to go out
   logic       tk;          // byte taken at this edge

   // queue a byte for delivery
   task automatic push(input logic [7:0] b);
      fifo_q.push_back(b);
   endtask

   // offer just after each edge and hold until taken
   initial begin
      byte_valid = 1'b0;
      byte_data  = 8'h00;
      tk         = 1'b0;
      forever begin
         @(posedge clk_sys);
         #1;
         if (tk) begin
            void'(fifo_q.pop_front());
         end
         if (fifo_q.size() > 0 && ((byte_valid && !tk) || $urandom_range(3) != 0)) begin
            byte_valid = 1'b1;
            byte_data  = fifo_q[0];
         end else begin
            // idle line toggles so a stale byte never passes for data
            byte_valid = 1'b0;
            byte_data  = ~byte_data;
         end
         // ready only moves on an edge, so its settled value holds for the coming edge
         tk = rst_n && byte_valid && byte_ready;
      end
   end
endmodule // ocdx_pfq_model

// File: dv/tb_opcode_decoder_xfer_arith.sv
// tb_opcode_decoder_xfer_arith: self-checking bench for the opcode decoder
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_opcode_decoder_xfer_arith;
   import ocdx_pkg::*;
   // expected result, field mask, wrong-adjust flag
   typedef struct packed {
      ocdx_dec_t e;
      ocdx_dec_t m;
      logic      bad;
   } ocdx_note_t;
   logic       clk_sys, rst_n, byte_valid, byte_ready, dec_valid, dec_bad_second, dec_ack;
   logic [7:0] byte_data;
   ocdx_dec_t  dec_out;
   ocdx_note_t notes [$];    // results still owed
   int         num_errors = 0;
   int         n_tests = 0;
   // single-byte opcodes and operations
   logic [7:0] sb [9] = '{OP_XLATE, OP_FLAGS_TO_AH, OP_AH_TO_FLAGS, OP_ASC_ADD_ADJ, OP_DEC_ADD_ADJ,
                          OP_ASC_SUB_ADJ, OP_DEC_SUB_ADJ, OP_BYTE_TO_WORD, OP_WORD_TO_DWORD};
   ocdx_op_t   so [9] = '{OCDX_XLATE, OCDX_FLAGS_TO_AH, OCDX_AH_TO_FLAGS, OCDX_ASC_ADD_ADJ, OCDX_DEC_ADD_ADJ,
                          OCDX_ASC_SUB_ADJ, OCDX_DEC_SUB_ADJ, OCDX_BYTE_TO_WORD, OCDX_WORD_TO_DWORD};
   // group operations by middle subcode
   ocdx_op_t   uop [8] = '{OCDX_ILLEGAL, OCDX_ILLEGAL, OCDX_NOT, OCDX_NEG, OCDX_MUL, OCDX_SIGNED_MULTIPLY, OCDX_DIV, OCDX_SIGNED_DIVIDE};
   ocdx_op_t   sop [8] = '{OCDX_ROL, OCDX_ROR, OCDX_RCL, OCDX_ILLEGAL, OCDX_SHL, OCDX_SHR, OCDX_ILLEGAL, OCDX_SAR};

   ocdx_decoder i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .byte_data(byte_data), .byte_valid(byte_valid),
      .byte_ready(byte_ready), .dec_out(dec_out), .dec_valid(dec_valid), .dec_bad_second(dec_bad_second),
      .dec_ack(dec_ack));
   ocdx_pfq_model i_pfq (.clk_sys(clk_sys), .rst_n(rst_n), .byte_ready(byte_ready), .byte_data(byte_data),
      .byte_valid(byte_valid));

   // 100 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   function automatic logic [7:0] rb();
      return 8'($urandom());
   endfunction

   // queue bytes and note the result; f: word, dest, count, imm and sign, fields, op ignored
   task automatic issue(input logic [7:0] b0, input logic [7:0] b1, input int n, input ocdx_op_t op,
                        input logic [5:0] f);
      ocdx_note_t t;
      t = '0;
      t.e.op = op;
      t.e.word = b0[0];
      t.e.reg_dest = b0[1];
      t.e.count_reg = b0[1];
      t.e.sign_ext = (b0[7:2] == PF_IMM_GRP) && b0[1];
      t.e.imm_bytes = (b0[7:2] == PF_IMM_GRP) ? ((b0[1:0] == 2'h1) ? 2'h2 : 2'h1) : (b0[0] ? 2'h2 : 2'h1);
      {t.e.mode, t.e.reg_field, t.e.rm_field} = b1;
      t.m.op = f[5] ? OCDX_NONE : ocdx_op_t'(6'h3f);
      {t.m.word, t.m.reg_dest, t.m.count_reg} = {f[0], f[1], f[2]};
      t.m.imm_bytes = {2{f[3]}};
      t.m.sign_ext = f[3];
      {t.m.mode, t.m.reg_field, t.m.rm_field} = {8{f[4]}};
      t.bad = (n == 2) && (b0[7:1] == 7'h6a) && (b1 != OP_ADJ_SECOND);
      notes.push_back(t);
      i_pfq.push(b0);
      if (n == 2) i_pfq.push(b1);
   endtask

   // wait until every owed result was seen
   task automatic end_test(input string s);
      for (int k = 0; k < 500 && (notes.size() > 0 || dec_valid !== 1'b0); k++) begin
         @(posedge clk_sys);
         #1;
      end
      `CHK(notes.size(), 0)
      `CHK(dec_valid, 1'b0)
      $display("test %s finished, %0d checks so far", s, n_tests);
   endtask

   task automatic final_report();
      $display("checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // result watcher: compare oldest note, then acknowledge after a random wait
   initial begin
      ocdx_note_t t;
      int         d;
      dec_ack = 1'b0;
      forever begin
         @(posedge clk_sys);
         #1;
         if (dec_valid === 1'b1) begin
            `CHK(notes.size() > 0, 1'b1)
            if (notes.size() > 0) begin
               t = notes.pop_front();
               `CHK(dec_out & t.m, t.e & t.m)
               `CHK(dec_bad_second, t.bad)
            end
            d = $urandom_range(2);
            repeat (d) begin
               @(posedge clk_sys);
               #1;
            end
            dec_ack = 1'b1;
            @(posedge clk_sys);
            #1;
            dec_ack = 1'b0;
         end
      end
   end

   // hang guard
   initial begin
      #100000;
      num_errors++;
      $display("watchdog expired");
      final_report();
   end

   // main sequence
   initial begin
      logic [7:0] m;
      rst_n = 1'b0;
      void'($urandom(33097));
      repeat (10) @(posedge clk_sys);
      #1;
      `CHK({byte_ready, dec_valid, dec_bad_second}, 3'b000)
      rst_n = 1'b1;
      @(posedge clk_sys);
      #1;
      `CHK(byte_ready, 1'b1)
      foreach (sb[i]) issue(sb[i], 8'h00, 1, so[i], 6'h00);
      issue(8'hf4, 8'h00, 1, OCDX_ILLEGAL, 6'h00);
      end_test("single byte");
      m = rb();
      issue(OP_SEG_LOAD, m & 8'hdf, 2, OCDX_SEG_LOAD, 6'h10);
      issue(OP_SEG_STORE, m & 8'hdf, 2, OCDX_SEG_STORE, 6'h10);
      issue(OP_SEG_LOAD, m | 8'h20, 2, OCDX_ILLEGAL, 6'h10);
      issue(OP_EA_LOAD, rb(), 2, OCDX_EA_LOAD, 6'h10);
      issue(OP_PTR_DS, rb(), 2, OCDX_PTR_DS, 6'h10);
      issue(OP_PTR_ES, rb(), 2, OCDX_PTR_ES, 6'h10);
      end_test("addressing byte");
      for (int i = 0; i < 4; i++) begin
         issue({PF_ADC_RM, i[1:0]}, rb(), 2, OCDX_ADC_RM, 6'h13);
         issue({PF_SUB_RM, i[1:0]}, rb(), 2, OCDX_SUB_RM, 6'h13);
         issue({PF_SBB_RM, i[1:0]}, rb(), 2, OCDX_SBB_RM, 6'h13);
         issue({PF_ADC_ACC, i[0]}, 8'h00, 1, OCDX_ADC_ACC, 6'h09);
         issue({PF_IMM_GRP, i[1:0]}, rb(), 2, OCDX_IMM_ARITH, 6'h19);
      end
      end_test("add and subtract");
      for (int i = 0; i < 8; i++) begin
         m = rb();
         if (i != 0) issue({PF_UNARY_GRP, m[0]}, {m[7:6], i[2:0], m[2:0]}, 2, uop[i], 6'h11);
         if (i != 3) issue({PF_SHIFT_GRP, m[1:0]}, {m[7:6], i[2:0], m[2:0]}, 2, sop[i], 6'h15);
      end
      end_test("subcode groups");
      issue(OP_ASC_MUL_ADJ, OP_ADJ_SECOND, 2, OCDX_ASC_MUL_ADJ, 6'h00);
      issue(OP_ASC_DIV_ADJ, OP_ADJ_SECOND, 2, OCDX_ASC_DIV_ADJ, 6'h00);
      issue(OP_ASC_DIV_ADJ, 8'h0b, 2, OCDX_ILLEGAL, 6'h00);
      end_test("two-byte adjust");
      final_report();
   end
endmodule // tb_opcode_decoder_xfer_arith

bind ocdx_decoder ocdx_asserts u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .byte_data(byte_data),
   .byte_valid(byte_valid), .byte_ready(byte_ready), .dec_out(dec_out), .dec_valid(dec_valid),
   .dec_bad_second(dec_bad_second), .dec_ack(dec_ack));
